// ==== rtl/ctk_defs.vh ====
// constants for the capacitive touch scan controller
`ifndef CTK_DEFS_VH
`define CTK_DEFS_VH

// ==========================================================
// register byte offsets
`define CTK_OFS_START 8'h00
`define CTK_OFS_CFG1 8'h04
`define CTK_OFS_CFG2 8'h08
`define CTK_OFS_ADDR 8'h0C
`define CTK_OFS_INT 8'h10
`define CTK_OFS_ANA 8'h14
`define CTK_OFS_SEL_LO 8'h18
`define CTK_OFS_SEL_HI 8'h1C
`define CTK_OFS_PULL 8'h20
`define CTK_OFS_RESULT 8'h24
`define CTK_OFS_MODCLK 8'h28
`define CTK_OFS_ANASW 8'h2C

// ==========================================================
// reset values
`define CTK_RST_CFG2 7'h70
`define CTK_RST_ANA 6'h2F
`define CTK_RST_PULL 9'h100
`define CTK_RST_ANASW 5'h07

// ==========================================================
// field positions
`define CTK_BIT_START 0
`define CTK_BIT_SW_GATE 6
`define CTK_BIT_PARALLEL 6
`define CTK_BIT_INT_EN 0
`define CTK_BIT_INT_FLAG 1
`define CTK_BIT_INT_CLR 2
`define CTK_BIT_CLKEN 19
`define CTK_BIT_PD 1
`define CTK_BIT_PRECH 1
`define CTK_BIT_DISCH 0
`define CTK_SEL_LO_RSVD 16

// ==========================================================
// divider and count clock figures
`define CTK_DIV_OFFSET 8'h04
`define CTK_PRS_NORMAL 6'h3E
`define CTK_PRS_EVEN 6'h3F
`define CTK_PRS_BASE 8'h09
`define CTK_CNT_P24M 8'h02
`define CTK_CNT_P12M 8'h04
`define CTK_CNT_P6M 8'h08
`define CTK_CNT_P4M 8'h0C
`define CTK_COUNTER_WIDTH_SELECT_BASE 9

// ==========================================================
// timing: times in microseconds, counts derived at 50 MHz
`define CTK_CLK_MHZ 50
`define CTK_PRECH_SHORT_US 20
`define CTK_PRECH_LONG_US 40
`define CTK_DISCH_SHORT_US 2
`define CTK_DISCH_LONG_US 10
// counts sized to the 11-bit phase timer: microseconds times 50
`define CTK_PRECH_SHORT_CYC 11'd1000
`define CTK_PRECH_LONG_CYC 11'd2000
`define CTK_DISCH_SHORT_CYC 11'd100
`define CTK_DISCH_LONG_CYC 11'd500

`endif

// ==== rtl/ctk_ticker.v ====
// programmable pulse divider: one pulse every period cycles
`timescale 1ns/1ns
`default_nettype none
module ctk_ticker #(
  parameter W = 8
) (
  input wire clk,
  input wire srst,
  input wire run,
  input wire [W-1:0] period,
  output wire tick
);
  reg [W-1:0] cnt_q;

  // ==========================================================
  // down counter, reloaded on each pulse
  assign tick = run && (cnt_q <= {{(W-1){1'b0}}, 1'b1});
  always @(posedge clk)
  begin
    if (srst || !run || tick)
      cnt_q <= period; // reload keeps the spacing exact
    else
      cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
  end
endmodule
`default_nettype wire

// ==== rtl/ctk_scan_ctrl.v ====
// capacitive touch scan controller with avalon-mm register slave
//
// Behaviour
// - scans can run only while clock enable bit 19 is set; off by default
// - front end powered down while power-down bit 1 of analog switch is set
// - start bit rising launches one scan; hardware clears it on finish
// - writing start 0 during a scan terminates it at once
// - configuration bit 6 stops the front-end switch clock when set
// - divider codes 0..61 give switch clock 50MHz/2/(code+4)
// - codes 62 and 63 give pseudo-random 1..3 MHz, normal or even spread
// - resolution field 6:4 sets counter width nine plus field value
// - count-clock field 3:2 selects 24, 12, 6 or 4 MHz counting
// - second config bit 1 selects 20 or 40 us pre-charge
// - second config bit 0 selects 2 or 10 us initial discharge
// - address bit 6 selects multi-channel parallel sensing
// - channel field 5:0 picks sense channel 0 to 59
// - writing 1 to interrupt config bit 2 clears done flag
// - status bit 1 reads 1 once a scan has completed
// - interrupt config bit 0 enables the completion interrupt
// - resistor field 5:3 takes 010 or 011, other codes reserved
// - threshold field 2:0 selects one of eight reference levels
// - low pin-select bits assign channels 0..31; bit 16 reserved
// - high pin-select bits 27:0 assign channels 32..59
// - pull-up current field 8:0 drives source switches, reset 0x100
// - result field 15:0 holds count of most recent scan
// - result is stored before the completion flag rises
// - abort returns internal scan control to reset state
`timescale 1ns/1ns
`default_nettype none
`include "ctk_defs.vh"
module ctk_scan_ctrl #(
  parameter NCH = 60
) (
  input wire clk,
  input wire srst,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire [NCH-1:0] sense_cmp,
  output reg front_end_switch_clock,
  output wire touch_power_down,
  output wire [2:0] series_resistor_select,
  output wire [2:0] threshold_level_select,
  output wire [8:0] pullup_current_field,
  output wire [NCH-1:0] sensor_pin_enable,
  output wire [5:0] sense_channel,
  output wire parallel_enable,
  output reg discharge_active,
  output reg precharge_active,
  output reg scan_busy,
  output wire irq
);
  localparam ST_IDLE = 3'd0;
  localparam ST_DISCH = 3'd1;
  localparam ST_PRECH = 3'd2;
  localparam ST_COUNT = 3'd3;
  localparam ST_STORE = 3'd4;
  localparam ST_FLAG = 3'd5;

  // software-visible state
  reg start_q;
  reg [6:0] cfg1_q;
  reg [6:0] cfg2_q;
  reg [6:0] addr_q;
  reg int_en_q;
  reg done_q;
  reg [5:0] ana_q;
  reg [31:0] sel_lo_q;
  reg [27:0] sel_hi_q;
  reg [8:0] pull_q;
  reg [15:0] result_q;
  reg clken_q;
  reg [4:0] anasw_q;

  // scan control state
  reg [2:0] st_q;
  reg [2:0] st_d;
  reg [10:0] tmr_q;
  reg [15:0] win_q;
  reg [15:0] evt_q;
  reg cmp_prev_q;
  reg [15:0] lfsr_q;
  reg ack_q;

  wire req;
  wire wr_en;
  wire rd_cap;
  wire [31:0] wmask;
  wire [31:0] wd;
  wire run_ok;
  wire start_wr;
  wire launch;
  wire abort;
  wire [5:0] div_code;
  wire sw_tick;
  wire cnt_tick;
  wire [3:0] nib_sum_lo;
  wire [4:0] nib_sum;
  reg [7:0] half_period;
  reg [7:0] cnt_period;
  wire [15:0] win_last;
  wire cmp_sel;
  wire cmp_rise;
  wire [10:0] prech_cyc;
  wire [10:0] disch_cyc;
  reg [31:0] rd_mux;

  // ==========================================================
  // avalon slave: one wait cycle, then the answer
  assign req = avs_read || avs_write;
  assign avs_waitrequest = req && !ack_q;
  assign wr_en = avs_write && ack_q;
  assign rd_cap = avs_read && !ack_q;
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wd = avs_writedata & wmask;

  // ack toggles so back-to-back requests each get a wait cycle
  always @(posedge clk)
  begin
    if (srst)
      ack_q <= 1'b0;
    else
      ack_q <= req && !ack_q;
  end

  // read data captured in the wait cycle, stands at the answer edge
  always @(posedge clk)
  begin
    if (srst)
      avs_readdata <= 32'h00000000;
    else if (rd_cap)
      avs_readdata <= rd_mux;
  end

  // ==========================================================
  // read mux: reserved bits and unmapped offsets read zero
  always @*
  begin
    rd_mux = 32'h00000000;
    case (avs_address)
      `CTK_OFS_START: rd_mux = {31'h00000000, start_q};
      `CTK_OFS_CFG1: rd_mux = {25'h0000000, cfg1_q};
      `CTK_OFS_CFG2: rd_mux = {25'h0000000, cfg2_q};
      `CTK_OFS_ADDR: rd_mux = {25'h0000000, addr_q};
      // clear bit is write-only and reads zero
      `CTK_OFS_INT: rd_mux = {29'h00000000, 1'b0, done_q, int_en_q};
      `CTK_OFS_ANA: rd_mux = {26'h0000000, ana_q};
      `CTK_OFS_SEL_LO: rd_mux = sel_lo_q;
      `CTK_OFS_SEL_HI: rd_mux = {4'h0, sel_hi_q};
      `CTK_OFS_PULL: rd_mux = {23'h000000, pull_q};
      `CTK_OFS_RESULT: rd_mux = {16'h0000, result_q};
      `CTK_OFS_MODCLK: rd_mux = {12'h000, clken_q, 19'h00000};
      `CTK_OFS_ANASW: rd_mux = {27'h0000000, anasw_q};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // ==========================================================
  // configuration registers with byte-lane writes
  always @(posedge clk)
  begin
    if (srst)
    begin
      cfg1_q <= 7'h00;
      cfg2_q <= `CTK_RST_CFG2;
      addr_q <= 7'h00;
      int_en_q <= 1'b0;
      ana_q <= `CTK_RST_ANA;
      sel_lo_q <= 32'h00000000;
      sel_hi_q <= 28'h0000000;
      pull_q <= `CTK_RST_PULL;
      clken_q <= 1'b0;
      anasw_q <= `CTK_RST_ANASW;
    end
    else if (wr_en)
    begin
      case (avs_address)
        `CTK_OFS_CFG1: cfg1_q <= (cfg1_q & ~wmask[6:0]) | wd[6:0];
        `CTK_OFS_CFG2: cfg2_q <= (cfg2_q & ~wmask[6:0]) | wd[6:0];
        `CTK_OFS_ADDR: addr_q <= (addr_q & ~wmask[6:0]) | wd[6:0];
        `CTK_OFS_INT:
        begin
          if (avs_byteenable[0])
            int_en_q <= avs_writedata[`CTK_BIT_INT_EN];
        end
        `CTK_OFS_ANA: ana_q <= (ana_q & ~wmask[5:0]) | wd[5:0];
        // bit 16 of the low select stays zero
        `CTK_OFS_SEL_LO:
          sel_lo_q <= ((sel_lo_q & ~wmask) | wd) & 32'hFFFEFFFF;
        `CTK_OFS_SEL_HI:
          sel_hi_q <= (sel_hi_q & ~wmask[27:0]) | wd[27:0];
        `CTK_OFS_PULL: pull_q <= (pull_q & ~wmask[8:0]) | wd[8:0];
        `CTK_OFS_MODCLK:
        begin
          if (avs_byteenable[2])
            clken_q <= avs_writedata[`CTK_BIT_CLKEN];
        end
        `CTK_OFS_ANASW: anasw_q <= (anasw_q & ~wmask[4:0]) | wd[4:0];
        default: clken_q <= clken_q;
      endcase
    end
  end

  // ==========================================================
  // analog and pad control outputs
  assign touch_power_down = anasw_q[`CTK_BIT_PD];
  assign series_resistor_select = ana_q[5:3];
  assign threshold_level_select = ana_q[2:0];
  assign pullup_current_field = pull_q;
  assign sensor_pin_enable = {sel_hi_q, sel_lo_q};
  assign sense_channel = addr_q[5:0];
  assign parallel_enable = addr_q[`CTK_BIT_PARALLEL];
  assign irq = done_q && int_en_q;

  // ==========================================================
  // start, abort and module gating
  // a disabled or powered-down module cannot scan at all
  assign run_ok = clken_q && !anasw_q[`CTK_BIT_PD];
  assign start_wr = wr_en && (avs_address == `CTK_OFS_START) &&
                    avs_byteenable[0];
  assign launch = start_wr && avs_writedata[`CTK_BIT_START] &&
                  !start_q && run_ok;
  assign abort = (start_wr && !avs_writedata[`CTK_BIT_START]) ||
                 !run_ok;

  // start bit: set by software, cleared by hardware with the flag
  always @(posedge clk)
  begin
    if (srst)
      start_q <= 1'b0;
    else if (abort)
      start_q <= 1'b0;
    else if (launch)
      start_q <= 1'b1;
    else if (st_q == ST_FLAG)
      start_q <= 1'b0;
  end

  // done flag: hardware set wins over a same-cycle software clear
  always @(posedge clk)
  begin
    if (srst)
      done_q <= 1'b0;
    else if (st_q == ST_FLAG)
      done_q <= 1'b1;
    else if (wr_en && (avs_address == `CTK_OFS_INT) &&
             avs_byteenable[0] && avs_writedata[`CTK_BIT_INT_CLR])
      done_q <= 1'b0;
  end

  // ==========================================================
  // front-end switch clock: fixed divider or pseudo-random spread
  assign div_code = cfg1_q[5:0];
  assign nib_sum = {1'b0, lfsr_q[3:0]} + {1'b0, lfsr_q[7:4]};
  assign nib_sum_lo = nib_sum[4:1];

  // half period in system cycles; fixed codes count at the 50 MHz system clock
  always @*
  begin
    half_period = {2'b00, div_code} + `CTK_DIV_OFFSET;
    if (div_code == `CTK_PRS_NORMAL)
      half_period = `CTK_PRS_BASE + {4'h0, nib_sum_lo};
    else if (div_code == `CTK_PRS_EVEN)
      half_period = `CTK_PRS_BASE + {4'h0, lfsr_q[3:0]};
  end

  ctk_ticker #(
    .W(8)
  ) u_sw_tick (
    .clk(clk),
    .srst(srst),
    .run(scan_busy && !cfg1_q[`CTK_BIT_SW_GATE]),
    .period(half_period),
    .tick(sw_tick)
  );

  // lfsr steps once per half period so each edge picks a new spacing
  always @(posedge clk)
  begin
    if (srst)
      lfsr_q <= 16'hACE1;
    else if (sw_tick)
      lfsr_q <= {lfsr_q[14:0],
                 lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
  end

  // switch clock is held low when gated or idle
  always @(posedge clk)
  begin
    if (srst || !scan_busy || cfg1_q[`CTK_BIT_SW_GATE])
      front_end_switch_clock <= 1'b0;
    else if (sw_tick)
      front_end_switch_clock <= !front_end_switch_clock;
  end

  // ==========================================================
  // count clock enable; 4 MHz rounds to 12 cycles at 50 MHz
  always @*
  begin
    case (cfg2_q[3:2])
      2'b00: cnt_period = `CTK_CNT_P24M;
      2'b01: cnt_period = `CTK_CNT_P12M;
      2'b10: cnt_period = `CTK_CNT_P6M;
      default: cnt_period = `CTK_CNT_P4M;
    endcase
  end

  ctk_ticker #(
    .W(8)
  ) u_cnt_tick (
    .clk(clk),
    .srst(srst),
    .run(st_q == ST_COUNT),
    .period(cnt_period),
    .tick(cnt_tick)
  );

  // ==========================================================
  // scan sequencing
  assign prech_cyc = cfg2_q[`CTK_BIT_PRECH] ? `CTK_PRECH_LONG_CYC :
                     `CTK_PRECH_SHORT_CYC;
  assign disch_cyc = cfg2_q[`CTK_BIT_DISCH] ? `CTK_DISCH_LONG_CYC :
                     `CTK_DISCH_SHORT_CYC;
  // window length is 2^(9+counter_width_select) count ticks
  assign win_last = 16'hFFFF >> (3'd7 - cfg2_q[6:4]);
  // parallel mode listens on every enabled pad
  assign cmp_sel = parallel_enable ? |(sense_cmp & sensor_pin_enable) :
                   sense_cmp[sense_channel];
  assign cmp_rise = cmp_sel && !cmp_prev_q;

  always @*
  begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: if (launch) st_d = ST_DISCH;
      ST_DISCH: if (tmr_q == disch_cyc - 11'd1) st_d = ST_PRECH;
      ST_PRECH: if (tmr_q == prech_cyc - 11'd1) st_d = ST_COUNT;
      ST_COUNT: if (cnt_tick && win_q == win_last) st_d = ST_STORE;
      ST_STORE: st_d = ST_FLAG;
      ST_FLAG: st_d = ST_IDLE;
      default: st_d = ST_IDLE;
    endcase
    if (abort)
      st_d = ST_IDLE;
  end

  // state, phase timer, window and event counters
  always @(posedge clk)
  begin
    if (srst)
    begin
      st_q <= ST_IDLE;
      tmr_q <= 11'd0;
      win_q <= 16'h0000;
      evt_q <= 16'h0000;
      cmp_prev_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      cmp_prev_q <= cmp_sel;
      if (st_d != st_q || abort)
        tmr_q <= 11'd0;
      else
        tmr_q <= tmr_q + 11'd1;
      if (st_q != ST_COUNT || abort)
      begin
        win_q <= 16'h0000;
        evt_q <= 16'h0000;
      end
      else
      begin
        if (cnt_tick)
          win_q <= win_q + 16'h0001;
        if (cmp_rise && evt_q != 16'hFFFF)
          evt_q <= evt_q + 16'h0001;
      end
    end
  end

  // result lands one cycle before the done flag rises
  always @(posedge clk)
  begin
    if (srst)
      result_q <= 16'h0000;
    else if (st_q == ST_STORE)
      result_q <= evt_q;
  end

  // ==========================================================
  // phase outputs to the analog front end
  always @(posedge clk)
  begin
    if (srst)
    begin
      discharge_active <= 1'b0;
      precharge_active <= 1'b0;
      scan_busy <= 1'b0;
    end
    else
    begin
      discharge_active <= (st_d == ST_DISCH);
      precharge_active <= (st_d == ST_PRECH);
      scan_busy <= (st_d != ST_IDLE);
    end
  end
endmodule
`default_nettype wire

// ==== verification/ctk_pad_model.sv ====
// sensor pad comparator model for the touch scan bench
`timescale 1ns/1ns
`default_nettype none
module ctk_pad_model #(
  parameter NCH = 60
) (
  input wire logic clk,
  input wire logic [NCH-1:0] sensor_pin_enable,
  output logic [NCH-1:0] sense_cmp
);
  int unsigned age_q = 0;
  // ==========================================================
  // pads
  // pad i swings with half period 5 + i%4; a pad not routed to the
  // sensor flips every cycle, so counting it by mistake is far off
  initial sense_cmp = '0;
  always @(posedge clk)
  begin
    age_q <= age_q + 1;
    for (int i = 0; i < NCH; i++)
      sense_cmp[i] <= sensor_pin_enable[i] ?
        ((age_q / (5 + i % 4)) % 2 == 1) : ~sense_cmp[i];
  end
endmodule
`default_nettype wire

// ==== verification/ctk_scan_chk.sv ====
// port assertions for the touch scan controller
`timescale 1ns/1ns
`default_nettype none
module ctk_scan_chk #(
  parameter NCH = 60
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic front_end_switch_clock,
  input wire logic touch_power_down,
  input wire logic [NCH-1:0] sensor_pin_enable,
  input wire logic discharge_active,
  input wire logic precharge_active,
  input wire logic scan_busy,
  input wire logic irq
);
  logic [11:0] dis_q;
  logic [11:0] pre_q;
  // ==========================================================
  // phase length counters, read at the falling edge of a phase
  always @(posedge clk)
  begin
    dis_q <= (srst || !discharge_active) ? 12'h000 : dis_q + 12'h001;
    pre_q <= (srst || !precharge_active) ? 12'h000 : pre_q + 12'h001;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // ==========================================================
  // assertions
  a_wait_first: assert property ($rose(avs_read || avs_write)
    |-> avs_waitrequest) else $error("no wait state on request");
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("more than one wait state");
  a_phase_excl: assert property (
    !(discharge_active && precharge_active))
    else $error("both phases active");
  a_phase_busy: assert property (
    (discharge_active || precharge_active) |-> scan_busy)
    else $error("phase outside a scan");
  a_scan_opens: assert property (
    $rose(scan_busy) |-> discharge_active && !precharge_active)
    else $error("scan not opened by discharge");
  a_disch_len: assert property (
    $fell(discharge_active) && scan_busy
    |-> precharge_active && (dis_q == 100 || dis_q == 500))
    else $error("discharge length wrong");
  a_prech_len: assert property (
    $fell(precharge_active) && scan_busy
    |-> (pre_q == 1000 || pre_q == 2000))
    else $error("precharge length wrong");
  a_irq_cause: assert property (
    $rose(irq) |-> $fell(scan_busy) || $past(avs_write))
    else $error("irq without cause");
  a_pd_stops: assert property (
    touch_power_down |=> !scan_busy)
    else $error("scan runs while powered down");
  a_switch_still: assert property (
    !scan_busy [*3] |-> $stable(front_end_switch_clock))
    else $error("switch clock moves when idle");
  a_pin_rsvd: assert property (
    !sensor_pin_enable[16])
    else $error("reserved pin enabled");
  c_scan_done: cover property ($fell(scan_busy) ##1 irq);
  c_abort: cover property (precharge_active ##1 !scan_busy);
  c_b2b: cover property (avs_write && !avs_waitrequest ##2 avs_read);
endmodule
bind ctk_scan_ctrl ctk_scan_chk #(.NCH(NCH)) u_chk (.*);
`default_nettype wire

// ==== verification/ctk_scan_ctrl_tb.sv ====
// self-checking bench for the touch scan controller
`timescale 1ns/1ns
`default_nettype none
`include "ctk_defs.vh"
module ctk_scan_ctrl_tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, front_end_switch_clock, touch_power_down;
  wire [59:0] sense_cmp, sensor_pin_enable;
  wire [2:0] series_resistor_select, threshold_level_select;
  wire [8:0] pullup_current_field;
  wire [5:0] sense_channel;
  wire parallel_enable, discharge_active, precharge_active, scan_busy, irq;
  int mismatches = 0;
  int total_checks = 0;
  int cyc = 0;
  int dis_n, pre_n, win_n, tog_n, hmin, hmax, since;
  logic busy_q, sw_q;
  logic [31:0] rdat, wv [13];
  logic [7:0] ofs [13] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14,
    8'h18, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h30};
  logic [31:0] rv [13] = '{32'h0, 32'h0, 32'h70, 32'h0, 32'h0, 32'h2F,
    32'h0, 32'h0, 32'h100, 32'h0, 32'h0, 32'h7, 32'h0};
  logic [31:0] msk [13] = '{32'h0, 32'h7F, 32'h7F, 32'h7F, 32'h1,
    32'h3F, 32'hFFFEFFFF, 32'h0FFFFFFF, 32'h1FF, 32'h0, 32'h80000,
    32'h1F, 32'h0};
  logic [6:0] corner [5] = '{7'h00, 7'h3D, 7'h3E, 7'h3F, 7'h45};
  logic [6:0] c1, c2;
  logic [5:0] ch;
  logic par = 1'b0;

  ctk_scan_ctrl #(.NCH(60)) DUT (.*);
  ctk_pad_model #(.NCH(60)) pads (.*);

  // ==========================================================
  // clock
  initial
  begin
    forever #10 clk = ~clk;
  end

  // ==========================================================
  // comparisons and verdict
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // counts whose start phase is not fixed get a tolerance
  task automatic near(input string nm, input logic [31:0] e,
                      input logic [31:0] g, input int tol);
    total_checks++;
    if (^g === 1'bx || g + tol < e || g > e + tol)
    begin
      mismatches++;
      $display("wrong value %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // counting window length in clocks for a second config value
  function automatic int win_len(input logic [6:0] v);
    int tick [4] = '{`CTK_CNT_P24M, `CTK_CNT_P12M, `CTK_CNT_P6M,
      `CTK_CNT_P4M};
    return tick[v[3:2]] << (`CTK_COUNTER_WIDTH_SELECT_BASE + v[6:4]);
  endfunction

  // ==========================================================
  // avalon master: hold until waitrequest low, then one idle edge
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 20)
      mismatches++;
    rdat = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  // ==========================================================
  // scan monitor and hang limit
  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 90000)
    begin
      mismatches++;
      complete_run();
    end
    if (scan_busy === 1'b1 && busy_q !== 1'b1)
    begin
      dis_n = 0;
      pre_n = 0;
      win_n = 0;
      tog_n = 0;
      hmin = 999;
      hmax = 0;
    end
    dis_n += discharge_active;
    pre_n += precharge_active;
    win_n += scan_busy && !discharge_active && !precharge_active;
    since++;
    if (scan_busy && front_end_switch_clock !== sw_q)
    begin
      if (tog_n > 0)
      begin
        hmin = since < hmin ? since : hmin;
        hmax = since > hmax ? since : hmax;
      end
      tog_n++;
      since = 0;
    end
    busy_q = scan_busy;
    sw_q = front_end_switch_clock;
  end

  // one full scan with its timing, status, count and flag clear
  task automatic run_scan(input logic en);
    int n;
    int w;
    n = 0;
    w = win_len(c2);
    bus(1, 8'h04, {25'h0, c1});
    bus(1, 8'h08, {25'h0, c2});
    // parallel mode points the address at a dead pad on purpose
    bus(1, 8'h0C, {25'h0, par, (par ? ch ^ 6'h01 : ch)});
    bus(1, 8'h10, {31'h0, en});
    bus(1, 8'h00, 32'h1);
    while (scan_busy !== 1'b0 && n < 60000)
    begin
      @(posedge clk);
      n++;
    end
    chk("discharge", c2[0] ? `CTK_DISCH_LONG_CYC : 100, dis_n);
    chk("precharge", c2[1] ? `CTK_PRECH_LONG_CYC : 1000, pre_n);
    near("window", w, win_n, 4);
    if (c1[6])
      chk("toggles", 0, tog_n);
    else if (c1[5:0] < 6'h3E)
    begin
      chk("half min", c1[5:0] + 4, hmin);
      chk("half max", c1[5:0] + 4, hmax);
    end
    else
    begin
      near("prs min", 16, hmin, 8);
      near("prs max", 16, hmax, 8);
    end
    bus(0, 8'h00, 0);
    chk("start", 0, rdat);
    chk("irq", en, irq);
    bus(0, 8'h24, 0);
    near("count", w / (2 * (5 + ch % 4)), rdat, 2);
    bus(1, 8'h10, {31'h0, en});
    bus(0, 8'h10, 0);
    chk("status", {30'h0, 1'b1, en}, rdat);
    bus(1, 8'h10, {29'h0, 1'b1, 1'b0, en});
    bus(0, 8'h10, 0);
    chk("cleared", en, rdat);
    chk("irq off", 0, irq);
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    void'($urandom(32'h74e2));
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 13; i++)
    begin
      bus(0, ofs[i], 0);
      chk("reset value", rv[i], rdat);
      wv[i] = $urandom;
      bus(1, ofs[i], wv[i]);
      bus(0, ofs[i], 0);
      chk("readback", wv[i] & msk[i], rdat);
      chk("idle", 0, scan_busy);
    end
    chk("pull pin", wv[8] & 32'h1FF, pullup_current_field);
    chk("pins lo", wv[6] & msk[6], sensor_pin_enable[31:0]);
    chk("pins hi", wv[7] & msk[7], sensor_pin_enable[59:32]);
    chk("analog", wv[5] & 32'h3F,
      {series_resistor_select, threshold_level_select});
    chk("channel", wv[3] & 32'h7F,
      {parallel_enable, sense_channel});
    chk("power", wv[11][1], touch_power_down);
    bus(1, 8'h28, 32'h0);
    bus(1, 8'h2C, 32'h5);
    bus(1, 8'h00, 32'h1);
    chk("no clock", 0, scan_busy);
    bus(1, 8'h28, 32'h1 << `CTK_BIT_CLKEN);
    bus(1, 8'h2C, 32'h7);
    bus(1, 8'h00, 32'h1);
    chk("blocked", 0, scan_busy);
    bus(1, 8'h2C, 32'h5);
    bus(1, 8'h18, 32'hFFFFFFFF);
    bus(1, 8'h1C, 32'h0FFFFFFF);
    bus(1, 8'h14, 32'h10 + $urandom_range(15));
    for (int k = 0; k < 9; k++)
    begin
      ch = 6'($urandom_range(59));
      if (ch == 6'h10)
        ch = 6'h11;
      c1 = k < 4 ? 7'($urandom_range(61)) : corner[k - 4];
      c2 = k < 4 ? {k < 3 ? k[2:0] : 3'h0, k[1:0],
        2'($urandom_range(3))} : 7'h00;
      run_scan(k[0]);
    end
    // parallel: only pad 33 enabled, others flip every cycle
    par = 1'b1;
    ch = 6'h21;
    bus(1, 8'h18, 32'h0);
    bus(1, 8'h1C, 32'h2);
    run_scan(1'b1);
    // abort by clearing start, then by powering down
    for (int k = 0; k < 2; k++)
    begin
      bus(1, 8'h00, 32'h1);
      repeat (300) @(posedge clk);
      bus(1, k ? 8'h2C : 8'h00, k ? 32'h7 : 32'h0);
      @(posedge clk);
      chk("aborted", 0,
        {scan_busy, discharge_active, precharge_active});
      bus(0, 8'h10, 0);
      chk("no flag", 0, rdat[1]);
      bus(1, 8'h2C, 32'h5);
    end
    complete_run();
  end
endmodule
`default_nettype wire
